// file: gpcb_bank.sv
// Purpose: Configuration bank for GPIO pins of ports 3 and 4
// Assumes: rst_n is the standby power-on reset; other resets are sync pulses
// Notes: Avalon-MM slave answers every request after one wait cycle
`timescale 1ns/1ps
module gpcb_bank (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic main_power_on_reset,
    input wire logic hard_reset,
    input wire gpcb_pkg::gpcb_avs_req_s avs_req,
    output gpcb_pkg::gpcb_avs_rsp_s avs_rsp,
    input wire logic [gpcb_pkg::NUM_PINS-1:0] pin_in,
    output logic [gpcb_pkg::NUM_PINS-1:0] pin_out,
    output logic [gpcb_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic [gpcb_pkg::NUM_PINS-1:0] gpio_out_data,
    output logic [gpcb_pkg::NUM_PINS-1:0] gpio_in_data,
    input wire gpcb_pkg::gpcb_alt_s alt,
    output logic infrared_receive_second,
    output logic irq
);

    // Whole state of the bank
    typedef struct packed {
        gpcb_pkg::gpcb_cfg_s [gpcb_pkg::NUM_PINS-1:0] cfg;
        gpcb_pkg::gpcb_avs_rsp_s rsp;
        gpcb_pkg::gpcb_pins_s pins;
        logic [gpcb_pkg::NUM_PINS-1:0] gpio_in;
        logic ir_rx;
        logic edge_prev;
        logic power_prev;
        logic [gpcb_pkg::NUM_EVT-1:0] status;
        logic [gpcb_pkg::NUM_EVT-1:0] enable;
        logic irq;
    } gpcb_state_s;

    gpcb_state_s st;      // Registered state
    gpcb_state_s next_st; // Next state

    // Per-pin wiring
    logic [gpcb_pkg::NUM_PINS-1:0] alt_on;
    logic [gpcb_pkg::NUM_PINS-1:0] alt_val;
    logic [gpcb_pkg::NUM_PINS-1:0] drv_out;
    logic [gpcb_pkg::NUM_PINS-1:0] drv_oe;
    logic [gpcb_pkg::NUM_PINS-1:0] in_val;

    // True when the index hits a pin register
    function automatic logic is_pin_reg(input logic [5:0] idx);
        return (idx >= gpcb_pkg::IDX_PIN_3_2) && (idx <= gpcb_pkg::IDX_PIN_4_2);
    endfunction

    // Slot of a pin register index
    function automatic logic [3:0] slot_of(input logic [5:0] idx);
        logic [5:0] diff;
        diff = idx - gpcb_pkg::IDX_PIN_3_2;
        return diff[3:0];
    endfunction

    // Writable bits of a slot; only pin 4.1 has a two-bit role
    function automatic logic [7:0] write_mask(input logic [3:0] slot);
        if (slot == 4'(gpcb_pkg::PIN_4_1)) begin
            return gpcb_pkg::MASK_TWO_ROLE;
        end
        return gpcb_pkg::MASK_ONE_ROLE;
    endfunction

    // Alternate sources in slot order; receive pin drives nothing of its own
    assign alt_val = {
        alt.power_event_out_n,
        alt.drive_density_select_1,
        alt.drive_density_select_0,
        alt.gate_a20_out,
        alt.keyboard_reset_out_n,
        alt.infrared_transmit_second,
        1'b0,
        alt.fan_speed_out_first,
        alt.fan_speed_out_second
    };

    // Output role select per pin
    always_comb begin
        for (int i = 0; i < gpcb_pkg::NUM_PINS; i++) begin
            alt_on[i] = st.cfg[i].role[0];
        end
        // Receive pin is an input role, its drive stays GPIO
        alt_on[gpcb_pkg::PIN_3_4] = 1'b0;
        // Only code 01 drives density select 1; 10 is an input role, 11 reserved
        alt_on[gpcb_pkg::PIN_4_1] = (st.cfg[gpcb_pkg::PIN_4_1].role == gpcb_pkg::ROLE_DENSITY);
    end

    // One driver per pin
    for (genvar g = 0; g < gpcb_pkg::NUM_PINS; g++) begin : g_pin
        gpcb_pin_drv u_drv (
            .cfg(st.cfg[g]),
            .alt_on(alt_on[g]),
            .alt_val(alt_val[g]),
            .gpio_val(gpio_out_data[g]),
            .pin_in(pin_in[g]),
            .pin_out(drv_out[g]),
            .pin_oe(drv_oe[g]),
            .in_val(in_val[g])
        );
    end

    // Bus, register, pin and event logic
    always_comb begin
        logic [5:0] idx;
        logic [3:0] slot;
        logic accept_wr;
        logic [gpcb_pkg::NUM_EVT-1:0] clr;
        logic [gpcb_pkg::NUM_EVT-1:0] set;
        logic edge_role;
        logic power_on;
        idx = avs_req.address[7:2];
        slot = slot_of(idx);
        accept_wr = avs_req.write && !st.rsp.waitrequest;
        clr = '0;
        set = '0;
        edge_role = 1'b0;
        power_on = 1'b0;
        next_st = st;

        // Wait one cycle, then answer; waitrequest low for exactly one edge
        next_st.rsp.waitrequest = 1'b1;
        next_st.rsp.readdata = 32'h0000_0000;
        if ((avs_req.read || avs_req.write) && st.rsp.waitrequest) begin
            next_st.rsp.waitrequest = 1'b0;
            if (avs_req.read) begin
                if (is_pin_reg(idx)) begin
                    next_st.rsp.readdata = {24'h00_0000, st.cfg[slot]};
                end else if (idx == gpcb_pkg::IDX_IRQ_STATUS) begin
                    next_st.rsp.readdata = {30'h0000_0000, st.status};
                end else if (idx == gpcb_pkg::IDX_IRQ_ENABLE) begin
                    next_st.rsp.readdata = {30'h0000_0000, st.enable};
                end
                // Unmapped and clear register read as zero
            end
        end

        // Writes land on the edge where waitrequest is seen low
        // Reserved bits are masked on the way in, so reads need no filter
        if (accept_wr) begin
            if (is_pin_reg(idx)) begin
                next_st.cfg[slot] = avs_req.writedata[7:0] & write_mask(slot);
            end else if (idx == gpcb_pkg::IDX_IRQ_CLEAR) begin
                clr = avs_req.writedata[gpcb_pkg::NUM_EVT-1:0];
            end else if (idx == gpcb_pkg::IDX_IRQ_ENABLE) begin
                next_st.enable = avs_req.writedata[gpcb_pkg::NUM_EVT-1:0];
            end
        end

        // Main power-on and hard reset; pins without a value here keep theirs
        // Placed after the bus write so a warm reset wins over a write in the same cycle
        if (main_power_on_reset || hard_reset) begin
            next_st.cfg[gpcb_pkg::PIN_3_2] = gpcb_pkg::RST_MAIN_FAN;
            next_st.cfg[gpcb_pkg::PIN_3_3] = gpcb_pkg::RST_MAIN_FAN;
            next_st.cfg[gpcb_pkg::PIN_3_5] = gpcb_pkg::RST_IR_TX;
        end

        // Registered pin drive and sampled inputs
        next_st.pins.out = drv_out;
        next_st.pins.oe = drv_oe;
        next_st.gpio_in = in_val;
        // Receive idles high while the pin is in GPIO role
        next_st.ir_rx = st.cfg[gpcb_pkg::PIN_3_4].role[0] ? in_val[gpcb_pkg::PIN_3_4] : 1'b1;

        // Either-edge interrupt input on pin 4.1
        // History follows the pin in every role, so picking the role raises no false edge
        edge_role = (st.cfg[gpcb_pkg::PIN_4_1].role == gpcb_pkg::ROLE_EDGE_IRQ);
        next_st.edge_prev = in_val[gpcb_pkg::PIN_4_1];
        set[gpcb_pkg::EVT_EDGE] = edge_role && (in_val[gpcb_pkg::PIN_4_1] != st.edge_prev);

        // Power event assertion seen while the pin carries it
        power_on = st.cfg[gpcb_pkg::PIN_4_2].role[0] && !alt.power_event_out_n;
        next_st.power_prev = power_on;
        set[gpcb_pkg::EVT_POWER] = power_on && !st.power_prev;

        // Set wins over clear
        next_st.status = (st.status & ~clr) | set;
        next_st.irq = |(next_st.status & next_st.enable);
    end

    // State register; standby reset loads the documented defaults
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.rsp.waitrequest <= 1'b1;
            st.cfg[gpcb_pkg::PIN_3_2] <= gpcb_pkg::RST_STBY_FAN;
            st.cfg[gpcb_pkg::PIN_3_3] <= gpcb_pkg::RST_STBY_FAN;
            st.cfg[gpcb_pkg::PIN_3_4] <= gpcb_pkg::RST_STBY_IR_RX;
            st.cfg[gpcb_pkg::PIN_3_5] <= gpcb_pkg::RST_IR_TX;
            st.cfg[gpcb_pkg::PIN_3_6] <= gpcb_pkg::RST_STBY_GPIO;
            st.cfg[gpcb_pkg::PIN_3_7] <= gpcb_pkg::RST_STBY_GPIO;
            st.cfg[gpcb_pkg::PIN_4_0] <= gpcb_pkg::RST_STBY_GPIO;
            st.cfg[gpcb_pkg::PIN_4_1] <= gpcb_pkg::RST_STBY_GPIO;
            st.cfg[gpcb_pkg::PIN_4_2] <= gpcb_pkg::RST_STBY_GPIO;
            st.ir_rx <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign avs_rsp = st.rsp;
    assign pin_out = st.pins.out;
    assign pin_oe = st.pins.oe;
    assign gpio_in_data = st.gpio_in;
    assign infrared_receive_second = st.ir_rx;
    assign irq = st.irq;

    // Checks on the bank
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Helper views of configuration fields
    logic [gpcb_pkg::NUM_PINS-1:0] dir_v;
    logic [gpcb_pkg::NUM_PINS-1:0] od_v;
    logic [gpcb_pkg::NUM_PINS-1:0] inv_v;
    always_comb begin
        for (int i = 0; i < gpcb_pkg::NUM_PINS; i++) begin
            dir_v[i] = st.cfg[i].input_dir;
            od_v[i] = st.cfg[i].open_drain;
            inv_v[i] = st.cfg[i].invert;
        end
    end

    // An input pin is never driven next cycle
    property p_input_no_drive;
        (pin_oe & $past(dir_v)) == '0;
    endproperty
    a_input_no_drive: assert property (p_input_no_drive) else $error("input pin driven");

    // GPIO output on pin 4.0 follows data through polarity
    property p_gpio_polarity;
        (!dir_v[gpcb_pkg::PIN_4_0] && !st.cfg[gpcb_pkg::PIN_4_0].role[0])
            |=> pin_out[gpcb_pkg::PIN_4_0] == ($past(gpio_out_data[gpcb_pkg::PIN_4_0]) ^ $past(inv_v[gpcb_pkg::PIN_4_0]));
    endproperty
    a_gpio_polarity: assert property (p_gpio_polarity) else $error("gpio polarity wrong");

    // Open-drain never drives high; push-pull output always drives
    // Pins are released during reset, so the first edge after it is skipped
    property p_driver_type;
        $past(rst_n)
            |-> ((pin_oe & pin_out & $past(od_v)) == '0) && ((~pin_oe & ~$past(dir_v) & ~$past(od_v)) == '0);
    endproperty
    a_driver_type: assert property (p_driver_type) else $error("driver type wrong");

    // Second fan output reaches pin 3.2 when routed
    property p_fan_route;
        (st.cfg[gpcb_pkg::PIN_3_2].role[0] && !dir_v[gpcb_pkg::PIN_3_2])
            |=> pin_out[gpcb_pkg::PIN_3_2] == ($past(alt.fan_speed_out_second) ^ $past(inv_v[gpcb_pkg::PIN_3_2]));
    endproperty
    a_fan_route: assert property (p_fan_route) else $error("fan route wrong");

    // First fan output reaches pin 3.3 when routed
    property p_fan_first_route;
        (st.cfg[gpcb_pkg::PIN_3_3].role[0] && !dir_v[gpcb_pkg::PIN_3_3])
            |=> pin_out[gpcb_pkg::PIN_3_3] == ($past(alt.fan_speed_out_first) ^ $past(inv_v[gpcb_pkg::PIN_3_3]));
    endproperty
    a_fan_first_route: assert property (p_fan_first_route) else $error("first fan route wrong");

    // Transmit source reaches pin 3.5 when routed
    property p_tx_route;
        (st.cfg[gpcb_pkg::PIN_3_5].role[0] && !dir_v[gpcb_pkg::PIN_3_5])
            |=> pin_out[gpcb_pkg::PIN_3_5]
                == ($past(alt.infrared_transmit_second) ^ $past(inv_v[gpcb_pkg::PIN_3_5]));
    endproperty
    a_tx_route: assert property (p_tx_route) else $error("transmit route wrong");

    // Receive output idles high while pin 3.4 keeps its GPIO role
    property p_receive_idle;
        !st.cfg[gpcb_pkg::PIN_3_4].role[0] |=> infrared_receive_second;
    endproperty
    a_receive_idle: assert property (p_receive_idle) else $error("receive output not idle");

    // Edge on pin 4.1 in interrupt role sets status within two cycles
    sequence s_edge_seen;
        (st.cfg[gpcb_pkg::PIN_4_1].role == gpcb_pkg::ROLE_EDGE_IRQ) && $changed(pin_in[gpcb_pkg::PIN_4_1]);
    endsequence
    property p_edge_irq;
        s_edge_seen ##1 (st.cfg[gpcb_pkg::PIN_4_1].role == gpcb_pkg::ROLE_EDGE_IRQ)
            |-> ##[0:1] st.status[gpcb_pkg::EVT_EDGE];
    endproperty
    a_edge_irq: assert property (p_edge_irq) else $error("edge event lost");

    // Power event asserted with no inversion drives the pin low
    property p_power_low;
        (st.cfg[gpcb_pkg::PIN_4_2].role[0] && !dir_v[gpcb_pkg::PIN_4_2] && !inv_v[gpcb_pkg::PIN_4_2]
            && !alt.power_event_out_n)
            |=> !pin_out[gpcb_pkg::PIN_4_2] && pin_oe[gpcb_pkg::PIN_4_2];
    endproperty
    a_power_low: assert property (p_power_low) else $error("power event not low");

    // Main and hard reset load fan and transmit defaults
    property p_main_reset;
        (main_power_on_reset || hard_reset)
            |=> (st.cfg[gpcb_pkg::PIN_3_2] == gpcb_pkg::RST_MAIN_FAN)
                && (st.cfg[gpcb_pkg::PIN_3_3] == gpcb_pkg::RST_MAIN_FAN)
                && (st.cfg[gpcb_pkg::PIN_3_5] == gpcb_pkg::RST_IR_TX);
    endproperty
    a_main_reset: assert property (p_main_reset) else $error("main reset value wrong");

    // Write accepted at this edge, as the bank sees it
    logic accept_wr_view;
    assign accept_wr_view = avs_req.write && !st.rsp.waitrequest;

    // Reserved bits 6:4 of a written pin register stay clear, as does bit 3 of pin 3.2
    property p_reserved_zero;
        (accept_wr_view && is_pin_reg(avs_req.address[7:2]))
            |=> st.cfg[$past(slot_of(avs_req.address[7:2]))].rsv == 3'h0
                && (st.cfg[gpcb_pkg::PIN_3_2].role[1] == 1'b0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit kept");

    // Every request is answered after exactly one wait cycle
    sequence s_req_start;
        (avs_req.read || avs_req.write) && avs_rsp.waitrequest;
    endsequence
    property p_bus_answer;
        s_req_start |=> !avs_rsp.waitrequest ##1 avs_rsp.waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

    // Interrupt line follows enabled status
    property p_irq_level;
        irq == |(st.status & st.enable);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

endmodule // gpcb_bank

// file: gpcb_pkg.sv
// Purpose: Shared constants and carriers for the GPIO pin configuration bank
// Assumes: One clock; registers reached over Avalon-MM with waitrequest
// Notes: Register offsets are indices; byte address is four times the index
package gpcb_pkg;

    // Pins handled by this bank, slot 0 is port 3 bit 2
    localparam int NUM_PINS = 9;
    localparam int NUM_EVT = 2;

    // Register indices of the pin configuration registers
    localparam logic [5:0] IDX_PIN_3_2 = 6'h35;
    localparam logic [5:0] IDX_PIN_3_3 = 6'h36;
    localparam logic [5:0] IDX_PIN_3_4 = 6'h37;
    localparam logic [5:0] IDX_PIN_3_5 = 6'h38;
    localparam logic [5:0] IDX_PIN_3_6 = 6'h39;
    localparam logic [5:0] IDX_PIN_3_7 = 6'h3a;
    localparam logic [5:0] IDX_PIN_4_0 = 6'h3b;
    localparam logic [5:0] IDX_PIN_4_1 = 6'h3c;
    localparam logic [5:0] IDX_PIN_4_2 = 6'h3d;

    // Register indices of the interrupt registers
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
    localparam logic [5:0] IDX_IRQ_CLEAR = 6'h11;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h12;

    // Slots of each pin inside the bank
    localparam int PIN_3_2 = 0;
    localparam int PIN_3_3 = 1;
    localparam int PIN_3_4 = 2;
    localparam int PIN_3_5 = 3;
    localparam int PIN_3_6 = 4;
    localparam int PIN_3_7 = 5;
    localparam int PIN_4_0 = 6;
    localparam int PIN_4_1 = 7;
    localparam int PIN_4_2 = 8;

    // Reset values
    localparam logic [7:0] RST_STBY_GPIO = 8'h01;
    localparam logic [7:0] RST_STBY_FAN = 8'h01;
    localparam logic [7:0] RST_MAIN_FAN = 8'h00;
    localparam logic [7:0] RST_STBY_IR_RX = 8'h05;
    localparam logic [7:0] RST_IR_TX = 8'h04;

    // Writable bits; reserved bits stay zero
    localparam logic [7:0] MASK_ONE_ROLE = 8'h87;
    localparam logic [7:0] MASK_TWO_ROLE = 8'h8f;

    // Role codes of the two-bit selector
    localparam logic [1:0] ROLE_GPIO = 2'h0;
    localparam logic [1:0] ROLE_DENSITY = 2'h1;
    localparam logic [1:0] ROLE_EDGE_IRQ = 2'h2;

    // Event bits in status, clear and enable
    localparam int EVT_EDGE = 0;
    localparam int EVT_POWER = 1;

    // Layout of one configuration byte
    typedef struct packed {
        logic open_drain;   // Bit 7
        logic [2:0] rsv;    // Bits 6:4
        logic [1:0] role;   // Bits 3:2, bit 2 alone in one-role pins
        logic invert;       // Bit 1
        logic input_dir;    // Bit 0
    } gpcb_cfg_s;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } gpcb_avs_req_s;

    // Avalon-MM answer to the master
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } gpcb_avs_rsp_s;

    // Alternate function sources driven by on-chip units
    typedef struct packed {
        logic fan_speed_out_second;
        logic fan_speed_out_first;
        logic infrared_transmit_second;
        logic keyboard_reset_out_n;
        logic gate_a20_out;
        logic drive_density_select_0;
        logic drive_density_select_1;
        logic power_event_out_n;
    } gpcb_alt_s;

    // Pin drive pair
    typedef struct packed {
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
    } gpcb_pins_s;

endpackage

// file: gpcb_pin_drv.sv
// Purpose: Per-pin direction, polarity and driver type
// Assumes: Pin input already synchronous to the clock
// Notes: Purely combinational; the caller registers the results
`timescale 1ns/1ps
module gpcb_pin_drv (
    input wire gpcb_pkg::gpcb_cfg_s cfg,
    input wire logic alt_on,
    input wire logic alt_val,
    input wire logic gpio_val,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic in_val
);

    // Source value after role select and polarity
    logic src;

    // Drive decision
    always_comb begin
        src = (alt_on ? alt_val : gpio_val) ^ cfg.invert;
        pin_out = src;
        if (cfg.input_dir) begin
            pin_oe = 1'b0;
        end else if (cfg.open_drain) begin
            pin_oe = ~src;
        end else begin
            pin_oe = 1'b1;
        end
        in_val = pin_in ^ cfg.invert;
    end

endmodule // gpcb_pin_drv

// file: gpcb_pin_partner.sv
// Purpose: Board side of the bank's pins: pull-ups and outside drivers
// Assumes: The bank drives a pin only while its pin_oe bit is high
// Notes: A released line floats high, so open-drain highs read as one
`timescale 1ns/1ps
module gpcb_pin_partner (
    input wire logic [gpcb_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [gpcb_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic [gpcb_pkg::NUM_PINS-1:0] ext_en,
    input wire logic [gpcb_pkg::NUM_PINS-1:0] ext_val,
    output logic [gpcb_pkg::NUM_PINS-1:0] pin_in
);
    // Resolve each wire; the bank wins, then an outside driver, then the pull-up
    always_comb begin
        for (int i = 0; i < gpcb_pkg::NUM_PINS; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i]; // Outside part drives an input pin
            end else begin
                pin_in[i] = 1'b1; // Pull-up, never the last driven value
            end
        end
    end
endmodule // gpcb_pin_partner

// file: tb_gpio_pin_config_bank_3_4.sv
// Purpose: Self-checking bench for the pin configuration bank
// Assumes: Bus answers after waitrequest drops; pins resolved by the partner
// Notes: Expected values come from the integer register model below
`timescale 1ns/1ps
module tb_gpio_pin_config_bank_3_4;
    localparam int NP = gpcb_pkg::NUM_PINS;
    logic clock = 1'b0; // 100 MHz
    logic rst_n = 1'b0; // Standby reset
    logic main_power_on_reset = 1'b0;
    logic hard_reset = 1'b0;
    gpcb_pkg::gpcb_avs_req_s avs_req = '0;
    gpcb_pkg::gpcb_avs_rsp_s avs_rsp;
    logic [NP-1:0] pin_in, pin_out, pin_oe, gpio_in_data;
    logic [NP-1:0] gpio_out_data = '0;
    logic [NP-1:0] ext_en = 9'h1f7; // Inputs after standby reset
    logic [NP-1:0] ext_val = '0;
    logic [7:0] alt_v = 8'hff; // Alternate sources, carrier bit order
    logic infrared_receive_second, irq;
    int n_fail = 0;
    int num_checks = 0;
    int mcfg [NP]; // Model of the configuration registers
    int abit [NP] = '{7, 6, -1, 5, 4, 3, 2, 1, 0}; // Source bit per slot
    int rst_v [NP] = '{1, 1, 5, 4, 1, 1, 1, 1, 1};
    logic [7:0] codes [5] = '{8'h04, 8'h06, 8'h84, 8'h00, 8'h85};
    logic [31:0] rnd = 32'h0000_2ec9;
    logic [31:0] rd;

    // Free-running clock
    always #5 clock = ~clock;

    gpcb_bank dut_u (.clock(clock), .rst_n(rst_n), .main_power_on_reset(main_power_on_reset),
        .hard_reset(hard_reset), .avs_req(avs_req), .avs_rsp(avs_rsp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .gpio_out_data(gpio_out_data),
        .gpio_in_data(gpio_in_data), .alt(gpcb_pkg::gpcb_alt_s'(alt_v)),
        .infrared_receive_second(infrared_receive_second), .irq(irq));

    gpcb_pin_partner pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    // Pseudo-random source, fixed start
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Byte address of a pin slot
    function automatic logic [7:0] ra(input int s);
        return {gpcb_pkg::IDX_PIN_3_2 + 6'(s), 2'b00};
    endfunction

    // Verdict, the single exit
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One transfer; held until waitrequest is sampled low, then one idle edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_req.read <= ~wr;
        avs_req.write <= wr;
        avs_req.address <= a;
        avs_req.writedata <= {24'h00_0000, d};
        @(posedge clock);
        while (avs_rsp.waitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                cmp(1'h0, 1'h1, "bus timeout");
                final_report();
            end
            @(posedge clock);
        end
        rd = avs_rsp.readdata;
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
        @(posedge clock);
    endtask

    // Write a pin register; reserved bits never reach the model
    task automatic wcfg(input int s, input logic [7:0] d);
        bus(1'b1, ra(s), d);
        mcfg[s] = d & (s == gpcb_pkg::PIN_4_1 ? gpcb_pkg::MASK_TWO_ROLE : gpcb_pkg::MASK_ONE_ROLE);
        ext_en[s] <= d[0]; // Outside driver only on inputs
    endtask

    task automatic rd_all(input string what);
        for (int s = 0; s < NP; s++) begin
            bus(1'b0, ra(s), 8'h00);
            cmp(rd, 32'(mcfg[s]), what);
        end
    endtask

    // New random pin, data and alternate source levels
    task automatic stir();
        rnd = lfsr(rnd);
        gpio_out_data <= rnd[8:0];
        ext_val <= rnd[17:9];
        alt_v <= rnd[25:18];
    endtask

    // Compare every pin against the model once outputs have settled
    task automatic chk_pins();
        logic [7:0] c;
        logic v, lv, on, l2;
        repeat (4) @(posedge clock);
        l2 = 1'b0;
        for (int s = 0; s < NP; s++) begin
            c = 8'(mcfg[s]);
            on = (s == gpcb_pkg::PIN_4_1) ? (c[3:2] == 2'h1) : (abit[s] >= 0 && c[2]);
            v = (on ? alt_v[abit[s]] : gpio_out_data[s]) ^ c[1];
            lv = c[0] ? ext_val[s] : v;
            cmp(pin_oe[s], c[0] ? 1'h0 : (c[7] ? !v : 1'h1), "drive enable");
            cmp(pin_in[s], lv, "pin level");
            cmp(gpio_in_data[s], lv ^ c[1], "input data");
            if (s == gpcb_pkg::PIN_3_4) begin
                l2 = lv ^ c[1];
            end
        end
        c = 8'(mcfg[gpcb_pkg::PIN_3_4]);
        cmp(infrared_receive_second, c[2] ? l2 : 1'h1, "receive role");
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        for (int s = 0; s < NP; s++) begin
            mcfg[s] = rst_v[s];
        end
        rd_all("standby reset value");
        chk_pins();
        $display("test reset values done");
        // Same code in every register: alternate on, inverted, open drain
        foreach (codes[k]) begin
            for (int s = 0; s < NP; s++) begin
                wcfg(s, codes[k]);
            end
            stir();
            chk_pins();
        end
        // All four role codes of pin 4.1
        for (int r = 0; r < 4; r++) begin
            wcfg(gpcb_pkg::PIN_4_1, 8'(r * 4 + 1));
            chk_pins();
        end
        $display("test roles done");
        for (int s = 0; s < NP; s++) begin
            wcfg(s, 8'hff);
        end
        rd_all("reserved bits");
        chk_pins();
        bus(1'b0, 8'h00, 8'h00);
        cmp(rd, 32'h0000_0000, "unmapped read");
        bus(1'b1, 8'hf8, 8'h5a);
        bus(1'b0, 8'hf8, 8'h00);
        cmp(rd, 32'h0000_0000, "unmapped write");
        rd_all("after unmapped write");
        $display("test reserved and unmapped done");
        // Main and hard reset pulses over a fully written bank
        for (int k = 0; k < 2; k++) begin
            for (int s = 0; s < NP; s++) begin
                wcfg(s, 8'hff);
            end
            if (k == 0) begin
                main_power_on_reset <= 1'b1;
            end else begin
                hard_reset <= 1'b1;
            end
            @(posedge clock);
            main_power_on_reset <= 1'b0;
            hard_reset <= 1'b0;
            @(posedge clock);
            mcfg[gpcb_pkg::PIN_3_2] = 0;
            mcfg[gpcb_pkg::PIN_3_3] = 0;
            mcfg[gpcb_pkg::PIN_3_5] = 4;
            rd_all("warm reset value");
            chk_pins();
        end
        $display("test warm resets done");
        // Random configurations with read-back
        repeat (30) begin
            rnd = lfsr(rnd);
            wcfg(rnd % NP, rnd[15:8]);
            stir();
            chk_pins();
            rd_all("random read-back");
        end
        $display("test random done");
        // Edge event on pin 4.1, then power event on pin 4.2
        alt_v <= 8'hff;
        ext_val <= '0;
        wcfg(gpcb_pkg::PIN_4_1, 8'h09);
        wcfg(gpcb_pkg::PIN_4_2, 8'h04);
        bus(1'b1, 8'h48, 8'h01);
        bus(1'b1, 8'h44, 8'h03);
        bus(1'b0, 8'h40, 8'h00);
        cmp(rd, 32'h0000_0000, "status cleared");
        cmp(irq, 1'h0, "irq idle");
        ext_val[7] <= 1'b1;
        repeat (4) @(posedge clock);
        bus(1'b0, 8'h40, 8'h00);
        cmp(rd, 32'h0000_0001, "edge status");
        cmp(irq, 1'h1, "edge irq");
        bus(1'b1, 8'h44, 8'h01);
        bus(1'b0, 8'h44, 8'h00);
        cmp(rd, 32'h0000_0000, "clear reads zero");
        cmp(irq, 1'h0, "irq after clear");
        bus(1'b1, 8'h48, 8'h00);
        ext_val[7] <= 1'b0;
        alt_v[0] <= 1'b0;
        repeat (4) @(posedge clock);
        bus(1'b0, 8'h40, 8'h00);
        cmp(rd, 32'h0000_0003, "masked status");
        cmp(irq, 1'h0, "masked irq");
        bus(1'b1, 8'h48, 8'h02);
        cmp(irq, 1'h1, "power event irq");
        $display("test interrupts done");
        final_report();
    end
endmodule // tb_gpio_pin_config_bank_3_4
